/* File: verilog/timer_control.sv */
// Purpose: Eight-bit down timer with prescaler and interrupt control port.
// Assumes: The CPU core drives port strobes and acknowledges on clk_sys.
// Notes: The external pin is asynchronous and is synchronised first.
`timescale 1ns/100ps
module timer_control (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] port_address,
    input wire logic port_write,
    input wire logic port_read,
    input wire logic [7:0] write_data,
    output logic [7:0] read_data,
    output logic read_hit,
    input wire logic external_request_pin,
    input wire logic timer_ack,
    input wire logic external_ack,
    output logic timer_request,
    output logic external_request,
    output logic serve_timer,
    output timer_port_pkg::timer_mode_t timer_mode
);
    import timer_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and edge detection.

    logic pin_meta;
    logic pin_sync;
    logic pin_last;
    logic pin_active;
    logic last_active;
    logic rise_edge;
    logic fall_edge;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_last <= 1'b0;
        end else begin
            pin_meta <= external_request_pin;
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    logic [7:0] timer_control_port;
    logic [7:0] next_timer_control_port;
    logic [7:0] control;

    assign control = timer_control_port;

    // Active level follows the level select; edges seen after it.
    assign pin_active = pin_sync == control[bit_active_level];
    assign last_active = pin_last == control[bit_active_level];
    assign rise_edge = pin_active && !last_active;
    assign fall_edge = !pin_active && last_active;

    ////////////////////////////////////////////////////////////////////////
    // Port decode.

    logic write_control;
    logic write_timer;

    assign write_control = port_write && port_address == port_control;
    assign write_timer = port_write && port_address == port_timer;

    always_comb begin
        next_timer_control_port = timer_control_port;
        if (write_control) begin
            next_timer_control_port = write_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            timer_control_port <= byte_zero;
        end else begin
            timer_control_port <= next_timer_control_port;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode and prescale ratio.

    logic prescale_any;
    logic [7:0] ratio;
    logic running;

    assign prescale_any = control[bit_div2] || control[bit_div5]
        || control[bit_div20];
    assign running = control[bit_start];

    always_comb begin
        if (!prescale_any) begin
            timer_mode = mode_event;
        end else if (control[bit_pulse_mode]) begin
            timer_mode = mode_pulse;
        end else begin
            timer_mode = mode_interval;
        end
    end

    // Set prescale bits multiply their factors.
    always_comb begin
        ratio = 8'((control[bit_div2] ? factor_two : factor_one)
            * (control[bit_div5] ? factor_five : factor_one)
            * (control[bit_div20] ? factor_twenty : factor_one));
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase clock and prescaler.

    logic phase_tick;
    logic scale_run;
    logic scale_clear;
    logic scale_tick;

    phase_divider #(
        .DIVIDE(phase_divide)
    ) phase_divider_inst (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .phase_tick(phase_tick)
    );

    // Stopped, pin inactive in pulse mode, or event mode hold it reset.
    assign scale_run = running && timer_mode != mode_event
        && (timer_mode != mode_pulse || pin_active);
    assign scale_clear = !running || write_timer
        || (timer_mode == mode_pulse && fall_edge);

    prescaler prescaler_inst (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clear(scale_clear),
        .run(scale_run),
        .phase_tick(phase_tick),
        .ratio(ratio),
        .scale_tick(scale_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Counter, reload register and request latches.

    logic [7:0] counter;
    logic [7:0] reload;
    logic timer_latch;
    logic external_latch;
    logic [7:0] next_counter;
    logic [7:0] next_reload;
    logic next_timer_latch;
    logic next_external_latch;
    logic count_step;
    logic wrap_now;
    logic external_event;

    always_comb begin
        if (timer_mode == mode_event) begin
            count_step = running && rise_edge;
        end else begin
            count_step = scale_tick;
        end
    end

    assign wrap_now = count_step && counter == count_last;
    assign external_event = (timer_mode == mode_pulse) ? fall_edge
        : rise_edge;

    always_comb begin
        next_counter = counter;
        next_reload = reload;
        next_timer_latch = timer_latch;
        next_external_latch = external_latch;
        if (write_timer) begin
            next_counter = write_data;
            next_reload = write_data;
        end else if (wrap_now) begin
            next_counter = reload;
        end else if (count_step) begin
            next_counter = counter - 8'h01;
        end
        if (timer_ack) begin
            next_timer_latch = 1'b0;
        end
        if (write_timer) begin
            next_timer_latch = 1'b0;
        end else if (wrap_now) begin
            next_timer_latch = 1'b1;
        end
        if (external_ack || !control[bit_ext_enable]) begin
            next_external_latch = 1'b0;
        end
        if (control[bit_ext_enable] && external_event) begin
            next_external_latch = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            counter <= byte_zero;
            reload <= byte_zero;
            timer_latch <= 1'b0;
            external_latch <= 1'b0;
        end else begin
            counter <= next_counter;
            reload <= next_reload;
            timer_latch <= next_timer_latch;
            external_latch <= next_external_latch;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Requests toward the CPU.

    assign timer_request = timer_latch && control[bit_timer_enable];
    assign external_request = external_latch;
    assign serve_timer = timer_request;

    ////////////////////////////////////////////////////////////////////////
    // Read port.

    logic [7:0] next_read_data;
    logic next_read_hit;

    always_comb begin
        next_read_data = byte_zero;
        next_read_hit = 1'b0;
        if (port_read && port_address == port_control) begin
            next_read_data[bit_pin_read] = pin_sync;
            next_read_hit = 1'b1;
        end else if (port_read && port_address == port_timer) begin
            next_read_data = counter;
            next_read_hit = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            read_data <= byte_zero;
            read_hit <= 1'b0;
        end else begin
            read_data <= next_read_data;
            read_hit <= next_read_hit;
        end
    end
endmodule

/* File: verilog/timer_port_pkg.sv */
// Purpose: Constants for the port-addressed timer and interrupt control port.
// Assumes: One system clock; phase clock derived as an enable pulse.
// Notes: Names every bit position, port number and factor.
package timer_port_pkg;
    localparam logic [3:0] port_control = 4'h6;
    localparam logic [3:0] port_timer = 4'h7;
    localparam int bit_ext_enable = 0;
    localparam int bit_timer_enable = 1;
    localparam int bit_active_level = 2;
    localparam int bit_start = 3;
    localparam int bit_pulse_mode = 4;
    localparam int bit_div2 = 5;
    localparam int bit_div5 = 6;
    localparam int bit_div20 = 7;
    localparam int bit_pin_read = 7;
    localparam logic [7:0] byte_zero = 8'h00;
    localparam logic [7:0] count_last = 8'h01;
    localparam logic [7:0] factor_one = 8'h01;
    localparam logic [7:0] factor_two = 8'h02;
    localparam logic [7:0] factor_five = 8'h05;
    localparam logic [7:0] factor_twenty = 8'h14;
    localparam int phase_divide = 2;
    typedef enum logic [1:0] {
        mode_interval,
        mode_pulse,
        mode_event
    } timer_mode_t;
endpackage

/* File: verilog/phase_divider.sv */
// Purpose: Makes the one-cycle phase clock enable from the system clock.
// Assumes: The system clock stands for the external time base.
// Notes: The phase rate is the system rate divided by DIVIDE.
`timescale 1ns/100ps
module phase_divider #(
    parameter int DIVIDE = 2
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    output logic phase_tick
);
    logic [7:0] count;
    logic [7:0] next_count;

    if (DIVIDE < 1 || DIVIDE > 255) begin : g_divide_check
        $error("phase_divider: DIVIDE out of range.");
    end

    always_comb begin
        if (count == 8'(DIVIDE - 1)) begin
            next_count = 8'h00;
        end else begin
            next_count = count + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            count <= 8'h00;
        end else begin
            count <= next_count;
        end
    end

    assign phase_tick = (count == 8'(DIVIDE - 1));
endmodule

/* File: verilog/prescaler.sv */
// Purpose: Divides phase ticks by a ratio and emits one tick per period.
// Assumes: The ratio is held stable while running.
// Notes: A clear restarts the division from its reset state.
`timescale 1ns/100ps
module prescaler (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic run,
    input wire logic phase_tick,
    input wire logic [7:0] ratio,
    output logic scale_tick
);
    import timer_port_pkg::*;
    logic [7:0] count;
    logic [7:0] next_count;
    logic wrap;

    assign wrap = (count + 8'h01 >= ratio);

    always_comb begin
        next_count = count;
        if (clear || !run) begin
            next_count = byte_zero;
        end else if (phase_tick) begin
            next_count = wrap ? byte_zero : count + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            count <= byte_zero;
        end else begin
            count <= next_count;
        end
    end

    assign scale_tick = run && !clear && phase_tick && wrap;
endmodule

/* File: testbench/timer_control_sva.sv */
// Purpose: Port checks of the timer control block.
// Assumes: The control byte is mirrored from port writes.
// Notes: Bound into every timer_control.
`timescale 1ns/100ps
module timer_control_sva (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] port_address,
    input wire logic port_write,
    input wire logic port_read,
    input wire logic [7:0] write_data,
    input wire logic [7:0] read_data,
    input wire logic read_hit,
    input wire logic external_request_pin,
    input wire logic timer_ack,
    input wire logic external_ack,
    input wire logic timer_request,
    input wire logic external_request,
    input wire logic serve_timer,
    input wire timer_port_pkg::timer_mode_t timer_mode
);
    import timer_port_pkg::*;
    logic [7:0] ctl;
    logic wr6;
    logic wr7;
    timer_mode_t want;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    assign wr6 = port_write && port_address == port_control;
    assign wr7 = port_write && port_address == port_timer;
    assign want = ctl[7:5] == 3'h0 ? mode_event :
        (ctl[4] ? mode_pulse : mode_interval);
    always_ff @(posedge clk_sys)
        if (!reset_n)
            ctl <= byte_zero;
        else if (wr6)
            ctl <= write_data;
    ////////////////////////////////////////
    sequence s_rd6; port_read && port_address == port_control; endsequence
    sequence s_zero; read_hit && read_data[6:0] == 7'h00; endsequence
    property p_rd6; s_rd6 |=> s_zero; endproperty
    a_rd6: assert property (p_rd6) else $error("control read");
    property p_miss;
        !(port_read && port_address[3:1] == 3'h3) |=> read_data == byte_zero;
    endproperty
    a_miss: assert property (p_miss) else $error("stray answer");
    property p_stray;
        port_read && port_address[3:1] != 3'h3 |=> !read_hit;
    endproperty
    a_stray: assert property (p_stray) else $error("stray hit");
    property p_wr7; wr7 |=> !timer_request; endproperty
    a_wr7: assert property (p_wr7) else $error("request kept");
    property p_mask; timer_request |-> ctl[1]; endproperty
    a_mask: assert property (p_mask) else $error("not masked");
    property p_hold;
        timer_request && !timer_ack && !wr6 && !wr7 |=> timer_request;
    endproperty
    a_hold: assert property (p_hold) else $error("request lost");
    property p_mode; !ctl[4] || ctl[7:5] != 3'h0 |-> timer_mode == want;
    endproperty
    a_mode: assert property (p_mode) else $error("wrong mode");
    property p_prio; timer_request && external_request |-> serve_timer;
    endproperty
    a_prio: assert property (p_prio) else $error("wrong order");
    property p_ext_off; wr6 && !write_data[0] |-> ##2 !external_request;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("ext kept");
endmodule
bind timer_control timer_control_sva timer_control_sva_inst (.*);

/* File: testbench/cpu_core_model.sv */
// Purpose: CPU core model making port accesses and acknowledges.
// Assumes: One operation at a time, each strobe one cycle long.
// Notes: Released address and data lines show inverted values.
`timescale 1ns/100ps
module cpu_core_model (
    input wire logic clk_sys,
    output logic [3:0] port_address,
    output logic port_write,
    output logic port_read,
    output logic [7:0] write_data,
    output logic timer_ack,
    output logic external_ack,
    input wire logic [7:0] read_data,
    input wire logic read_hit
);
    initial {port_address, write_data, port_write, port_read, timer_ack,
        external_ack} = 16'h0000;
    // Kind 0 reads, 1 writes, 2 acknowledges the timer, 3 the pin.
    task automatic access(input logic [3:0] a, input logic [7:0] d,
                          input logic [1:0] k);
        @(posedge clk_sys);
        port_address <= a;
        write_data <= d;
        port_read <= k == 2'h0;
        port_write <= k == 2'h1;
        timer_ack <= k == 2'h2;
        external_ack <= k == 2'h3;
        @(posedge clk_sys);
        {port_write, port_read, timer_ack, external_ack} <= 4'h0;
        port_address <= ~a;
        write_data <= ~d;
    endtask
endmodule

/* File: testbench/timer_control_tb.sv */
// Purpose: Self-checking bench of the timer control block.
// Assumes: A CPU core model makes every port access.
// Notes: Waits are counted in 50 ns cycles.
`timescale 1ns/100ps
module timer_control_tb;
    import timer_port_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic external_request_pin = 1'b0;
    logic [3:0] port_address;
    logic [7:0] write_data, read_data, v, w;
    logic port_write, port_read, read_hit, timer_ack, external_ack;
    logic timer_request, external_request, serve_timer;
    timer_mode_t timer_mode;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    timer_control timer_control_inst (.*);
    cpu_core_model cpu_core_model_inst (.*);
    initial forever #25 clk_sys = ~clk_sys;
    task automatic complete_run();
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic op(input logic [3:0] a, input logic [7:0] d,
                      input logic [1:0] k);
        cpu_core_model_inst.access(a, d, k);
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        op(a, 8'h00, 2'h0);
        chk({7'h0, read_hit}, 8'h01);
        d = read_data;
    endtask
    task automatic pin_to(input logic p, input int n);
        @(posedge clk_sys);
        external_request_pin <= p;
        step(n);
    endtask
    task automatic wait_timer(input int n);
        for (int i = 0; i < n && timer_request !== 1'b1; i++)
            step(1);
        chk({7'h0, timer_request}, 8'h01);
    endtask
    ////////////////////////////////////////
    task automatic t_interval();
        rd(port_control, v);
        chk(v, 8'h00);
        op(4'h5, 8'hff, 2'h1);
        op(4'h5, 8'h00, 2'h0);
        chk({read_hit, 7'h0}, 8'h00);
        chk(read_data, 8'h00);
        rd(port_timer, v);
        chk(v, 8'h00);
        op(port_timer, 8'h03, 2'h1);
        op(port_control, 8'h2a, 2'h1);
        wait_timer(40);
        rd(port_timer, v);
        chk(v, 8'h03);
        op(port_control, 8'h28, 2'h1);
        chk({7'h0, timer_request}, 8'h00);
        step(20);
        op(port_control, 8'h2a, 2'h1);
        chk({7'h0, timer_request}, 8'h01);
        op(port_timer, 8'h00, 2'h1);
        chk({7'h0, timer_request}, 8'h00);
        step(1000);
        chk({7'h0, timer_request}, 8'h00);
        wait_timer(60);
    endtask
    task automatic t_event();
        op(port_control, 8'h0c, 2'h1);
        op(port_timer, 8'h05, 2'h1);
        repeat (3) begin
            pin_to(1'b1, 4);
            pin_to(1'b0, 4);
        end
        rd(port_timer, v);
        chk(v, 8'h02);
        op(port_control, 8'h04, 2'h1);
        pin_to(1'b1, 4);
        pin_to(1'b0, 4);
        rd(port_timer, v);
        chk(v, 8'h02);
        op(port_control, 8'h0c, 2'h1);
        pin_to(1'b1, 4);
        rd(port_timer, v);
        chk(v, 8'h01);
        rd(port_control, v);
        chk(v, 8'h80);
    endtask
    task automatic t_ext();
        op(port_timer, 8'h02, 2'h1);
        op(port_control, 8'h2b, 2'h1);
        pin_to(1'b0, 5);
        wait_timer(40);
        chk({6'h0, external_request, serve_timer}, 8'h03);
        op(port_control, 8'h2b, 2'h3);
        chk({7'h0, external_request}, 8'h00);
        pin_to(1'b1, 4);
        pin_to(1'b0, 5);
        chk({7'h0, external_request}, 8'h01);
        op(port_control, 8'h22, 2'h1);
        step(2);
        chk({6'h0, external_request, timer_request}, 8'h01);
        op(port_control, 8'h00, 2'h2);
        chk({7'h0, timer_request}, 8'h00);
    endtask
    task automatic t_pulse();
        op(port_timer, 8'h80, 2'h1);
        op(port_control, 8'h3d, 2'h1);
        step(20);
        rd(port_timer, v);
        chk(v, 8'h80);
        pin_to(1'b1, 40);
        pin_to(1'b0, 5);
        chk({7'h0, external_request}, 8'h01);
        rd(port_timer, v);
        step(20);
        rd(port_timer, w);
        chk(w, v);
        chk({7'h0, v < 8'h80}, 8'h01);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        step(1);
        t_interval();
        t_event();
        t_ext();
        t_pulse();
        complete_run();
    end
endmodule
